// ===== rtl/metering_config_status_regs.sv
// Configuration and second-tier status register bank of the metering core
// Contract
// - Autocal flags set first-tier summary bit
// - Autocal read returns then clears
// - Event on clearing cycle stays set
// - Quality flags: RO, zero reset, clear-on-read
// - Fault flags: RO, zero reset, clear-on-read
// - Code 0x0052 selects fast baud
// - Refresh write triggers checksum recompute
// - Write guard register, reset zero
// - Power interval, reset 0x00FF
// - Energy interval, reset 0x00FF
// - Channel A amplifier gain register
// - Thermal setup RW, result RO
// - Accumulation config register, reset zero
`timescale 1ns/1ps
module metering_config_status_regs
   import meter_regs_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Register port
   input wire logic [meter_regs_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [meter_regs_pkg::DATA_W-1:0] reg_wdata_in,
   output logic [meter_regs_pkg::DATA_W-1:0] reg_rdata_out,
   output logic reg_rvalid_out,
   // Status sources
   input wire logic [meter_regs_pkg::DATA_W-1:0] autocal_event_in,
   input wire logic [meter_regs_pkg::DATA_W-1:0] quality_event_in,
   input wire logic [meter_regs_pkg::DATA_W-1:0] fault_event_in,
   input wire logic [meter_regs_pkg::DATA_W-1:0] thermal_value_in,
   input wire logic thermal_valid_in,
   // Configuration to the core
   output logic [meter_regs_pkg::DATA_W-1:0] accum_config_out,
   output logic [meter_regs_pkg::DATA_W-1:0] power_update_interval_out,
   output logic [meter_regs_pkg::DATA_W-1:0] energy_update_interval_out,
   output logic [meter_regs_pkg::DATA_W-1:0] thermal_sensor_setup_out,
   output logic [meter_regs_pkg::DATA_W-1:0] programmable_amplifier_gain_out,
   output logic [meter_regs_pkg::DATA_W-1:0] config_write_guard_out,
   output logic uart_fast_baud_out,
   output logic checksum_refresh_out,
   // First-tier summary bits
   output logic [meter_regs_pkg::NUM_TIER2-1:0] tier1_summary_out
);
   import meter_regs_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0] accum_config;
      logic [DATA_W-1:0] power_update_interval;
      logic [DATA_W-1:0] energy_update_interval;
      logic [DATA_W-1:0] thermal_sensor_setup;
      logic [DATA_W-1:0] thermal_result;
      logic [DATA_W-1:0] chan_a_amp_gain;
      logic [DATA_W-1:0] config_write_guard;
      logic fast_baud;
      logic [DATA_W-1:0] rdata;
      logic rvalid;
      logic [NUM_TIER2-1:0] summary;
   } bank_state_t;

   bank_state_t state, next_state;
   logic [DATA_W-1:0] flags [NUM_TIER2];
   logic [DATA_W-1:0] events [NUM_TIER2];
   logic [NUM_TIER2-1:0] clear_rd;
   logic refresh_wr;
   logic [DATA_W-1:0] tier_next [NUM_TIER2];

   assign events[IDX_AUTOCAL] = autocal_event_in;
   assign events[IDX_QUALITY] = quality_event_in;
   assign events[IDX_FAULT] = fault_event_in;

   assign clear_rd[IDX_AUTOCAL] = reg_rd_in && (reg_addr_in == OFS_AUTOCAL_TIER2_FLAGS);
   assign clear_rd[IDX_QUALITY] = reg_rd_in && (reg_addr_in == OFS_QUALITY_TIER2_FLAGS);
   assign clear_rd[IDX_FAULT] = reg_rd_in && (reg_addr_in == OFS_FAULT_TIER2_FLAGS);
   assign refresh_wr = reg_wr_in && (reg_addr_in == OFS_CHECKSUM_REFRESH);

   // Second-tier flag registers
   genvar g;
   generate
      for (g = 0; g < NUM_TIER2; g++) begin : gen_tier2
         assign tier_next[g] = (clear_rd[g] ? '0 : flags[g]) | events[g];
         tier2_flag_reg #(
            .WIDTH(DATA_W)
         ) u_flags (
            .ref_clk_in(ref_clk_in),
            .rst_in(rst_in),
            .event_in(events[g]),
            .clear_in(clear_rd[g]),
            .flags_out(flags[g])
         );
      end
   endgenerate

   checksum_refresh_pulse u_refresh (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .write_in(refresh_wr),
      .refresh_out(checksum_refresh_out)
   );

   always_comb begin
      next_state = state;
      next_state.rvalid = reg_rd_in;
      next_state.rdata = RST_ZERO;
      if (thermal_valid_in) begin
         next_state.thermal_result = thermal_value_in;
      end
      if (reg_wr_in) begin
         case (reg_addr_in)
            OFS_ACCUM_CONFIG: begin
               next_state.accum_config = reg_wdata_in;
            end
            OFS_POWER_UPDATE_INTERVAL: begin
               next_state.power_update_interval = reg_wdata_in;
            end
            OFS_ENERGY_UPDATE_INTERVAL: begin
               next_state.energy_update_interval = reg_wdata_in;
            end
            OFS_THERMAL_SENSOR_SETUP: begin
               next_state.thermal_sensor_setup = reg_wdata_in;
            end
            OFS_CHAN_A_AMP_GAIN: begin
               next_state.chan_a_amp_gain = reg_wdata_in;
            end
            OFS_CONFIG_WRITE_GUARD: begin
               next_state.config_write_guard = reg_wdata_in;
            end
            OFS_SERIAL_RATE_SELECT: begin
               next_state.fast_baud = (reg_wdata_in == FAST_BAUD_CODE);
            end
            OFS_CHECKSUM_REFRESH: begin
            end
            OFS_THERMAL_RESULT,
            OFS_AUTOCAL_TIER2_FLAGS,
            OFS_QUALITY_TIER2_FLAGS,
            OFS_FAULT_TIER2_FLAGS: begin
            end
            default: begin
               next_state.fast_baud = state.fast_baud;
            end
         endcase
      end
      if (reg_rd_in) begin
         case (reg_addr_in)
            OFS_ACCUM_CONFIG: begin
               next_state.rdata = state.accum_config;
            end
            OFS_POWER_UPDATE_INTERVAL: begin
               next_state.rdata = state.power_update_interval;
            end
            OFS_ENERGY_UPDATE_INTERVAL: begin
               next_state.rdata = state.energy_update_interval;
            end
            OFS_THERMAL_SENSOR_SETUP: begin
               next_state.rdata = state.thermal_sensor_setup;
            end
            OFS_THERMAL_RESULT: begin
               next_state.rdata = state.thermal_result;
            end
            OFS_CHAN_A_AMP_GAIN: begin
               next_state.rdata = state.chan_a_amp_gain;
            end
            OFS_CONFIG_WRITE_GUARD: begin
               next_state.rdata = state.config_write_guard;
            end
            OFS_AUTOCAL_TIER2_FLAGS: begin
               next_state.rdata = flags[IDX_AUTOCAL];
            end
            OFS_QUALITY_TIER2_FLAGS: begin
               next_state.rdata = flags[IDX_QUALITY];
            end
            OFS_FAULT_TIER2_FLAGS: begin
               next_state.rdata = flags[IDX_FAULT];
            end
            OFS_CHECKSUM_REFRESH,
            OFS_SERIAL_RATE_SELECT: begin
               next_state.rdata = RST_ZERO;
            end
            default: begin
               next_state.rdata = RST_ZERO;
            end
         endcase
      end
      for (int i = 0; i < NUM_TIER2; i++) begin
         next_state.summary[i] = |tier_next[i];
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state.accum_config <= RST_ZERO;
         state.power_update_interval <= RST_UPDATE_INTERVAL;
         state.energy_update_interval <= RST_UPDATE_INTERVAL;
         state.thermal_sensor_setup <= RST_ZERO;
         state.thermal_result <= RST_ZERO;
         state.chan_a_amp_gain <= RST_ZERO;
         state.config_write_guard <= RST_ZERO;
         state.fast_baud <= 1'b0;
         state.rdata <= RST_ZERO;
         state.rvalid <= 1'b0;
         state.summary <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata_out = state.rdata;
   assign reg_rvalid_out = state.rvalid;
   assign accum_config_out = state.accum_config;
   assign power_update_interval_out = state.power_update_interval;
   assign energy_update_interval_out = state.energy_update_interval;
   assign thermal_sensor_setup_out = state.thermal_sensor_setup;
   assign programmable_amplifier_gain_out = state.chan_a_amp_gain;
   assign config_write_guard_out = state.config_write_guard;
   assign uart_fast_baud_out = state.fast_baud;
   assign tier1_summary_out = state.summary;
endmodule

// ===== rtl/meter_regs_pkg.sv
// Register map, reset values and widths for the configuration and status bank
package meter_regs_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   localparam logic [11:0] OFS_ACCUM_CONFIG = 12'h04b0;
   localparam logic [11:0] OFS_POWER_UPDATE_INTERVAL = 12'h04b1;
   localparam logic [11:0] OFS_ENERGY_UPDATE_INTERVAL = 12'h04b2;
   localparam logic [11:0] OFS_CHECKSUM_REFRESH = 12'h04b4;
   localparam logic [11:0] OFS_THERMAL_SENSOR_SETUP = 12'h04b6;
   localparam logic [11:0] OFS_THERMAL_RESULT = 12'h04b7;
   localparam logic [11:0] OFS_CHAN_A_AMP_GAIN = 12'h04b9;
   localparam logic [11:0] OFS_CONFIG_WRITE_GUARD = 12'h04bf;
   localparam logic [11:0] OFS_AUTOCAL_TIER2_FLAGS = 12'h04c0;
   localparam logic [11:0] OFS_QUALITY_TIER2_FLAGS = 12'h04c1;
   localparam logic [11:0] OFS_FAULT_TIER2_FLAGS = 12'h04c2;
   localparam logic [11:0] OFS_SERIAL_RATE_SELECT = 12'h04dc;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [15:0] RST_UPDATE_INTERVAL = 16'h00ff;
   localparam logic [15:0] FAST_BAUD_CODE = 16'h0052;
   localparam int NUM_TIER2 = 3;
   localparam int IDX_AUTOCAL = 0;
   localparam int IDX_QUALITY = 1;
   localparam int IDX_FAULT = 2;
endpackage

// ===== rtl/tier2_flag_reg.sv
// One clear-on-read second-tier status register
`timescale 1ns/1ps
module tier2_flag_reg
   import meter_regs_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Events and clearing read
   input wire logic [WIDTH-1:0] event_in,
   input wire logic clear_in,
   // Held flags
   output logic [WIDTH-1:0] flags_out
);
   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } flag_state_t;
   flag_state_t state, next_state;

   always_comb begin
      next_state = state;
      next_state.flags = (clear_in ? '0 : state.flags) | event_in;
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign flags_out = state.flags;
endmodule

// ===== rtl/checksum_refresh_pulse.sv
// Turns a checksum refresh write into a one-cycle request pulse
`timescale 1ns/1ps
module checksum_refresh_pulse (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Write strobe
   input wire logic write_in,
   // Registered pulse
   output logic refresh_out
);
   typedef struct packed {
      logic pulse;
   } pulse_state_t;
   pulse_state_t state, next_state;

   always_comb begin
      next_state = state;
      next_state.pulse = write_in;
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign refresh_out = state.pulse;
endmodule

// ===== dv/metering_regs_properties.sv
// Port assertions for the metering register bank
`timescale 1ns/1ps
module metering_regs_checker (
   // Clock, reset and register port
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [11:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_rvalid_out,
   // Events and outputs
   input wire logic [15:0] autocal_event_in,
   input wire logic [15:0] quality_event_in,
   input wire logic [15:0] fault_event_in,
   input wire logic [15:0] accum_config_out,
   input wire logic [15:0] programmable_amplifier_gain_out,
   input wire logic uart_fast_baud_out,
   input wire logic checksum_refresh_out,
   input wire logic [2:0] tier1_summary_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   property p_rd_answer; reg_rd_in |=> reg_rvalid_out; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_baud; reg_wr_in && reg_addr_in == 12'h04dc |=>
      uart_fast_baud_out == ($past(reg_wdata_in) == 16'h0052); endproperty
   a_baud: assert property (p_baud) else $error("baud select wrong");
   property p_refresh; reg_wr_in && reg_addr_in == 12'h04b4 |=> checksum_refresh_out; endproperty
   a_refresh: assert property (p_refresh) else $error("refresh missing");
   property p_refresh_cause; checksum_refresh_out |->
      $past(reg_wr_in) && $past(reg_addr_in) == 12'h04b4; endproperty
   a_refresh_cause: assert property (p_refresh_cause) else $error("stray refresh");
   property p_gain; reg_wr_in && reg_addr_in == 12'h04b9 |=>
      programmable_amplifier_gain_out == $past(reg_wdata_in); endproperty
   a_gain: assert property (p_gain) else $error("gain not written");
   property p_accum_hold; !(reg_wr_in && reg_addr_in == 12'h04b0) |=>
      $stable(accum_config_out); endproperty
   a_accum_hold: assert property (p_accum_hold) else $error("accum config changed");
   property p_autocal_set; autocal_event_in != 16'h0000 |=> tier1_summary_out[0]; endproperty
   a_autocal_set: assert property (p_autocal_set) else $error("autocal summary low");
   property p_autocal_clear; reg_rd_in && reg_addr_in == 12'h04c0 &&
      autocal_event_in == 16'h0000 |=> !tier1_summary_out[0]; endproperty
   a_autocal_clear: assert property (p_autocal_clear) else $error("autocal not cleared");
   property p_quality_set; quality_event_in != 16'h0000 |=> tier1_summary_out[1]; endproperty
   a_quality_set: assert property (p_quality_set) else $error("quality summary low");
   property p_fault_set; fault_event_in != 16'h0000 |=> tier1_summary_out[2]; endproperty
   a_fault_set: assert property (p_fault_set) else $error("fault summary low");
   c_fast: cover property (uart_fast_baud_out);
   c_refresh: cover property (checksum_refresh_out);
   c_clear_race: cover property (reg_rd_in && autocal_event_in != 16'h0000);
endmodule
bind metering_config_status_regs metering_regs_checker u_chk (
   .ref_clk_in(ref_clk_in),
   .rst_in(rst_in),
   .reg_addr_in(reg_addr_in),
   .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in),
   .reg_wdata_in(reg_wdata_in),
   .reg_rvalid_out(reg_rvalid_out),
   .autocal_event_in(autocal_event_in),
   .quality_event_in(quality_event_in),
   .fault_event_in(fault_event_in),
   .accum_config_out(accum_config_out),
   .programmable_amplifier_gain_out(programmable_amplifier_gain_out),
   .uart_fast_baud_out(uart_fast_baud_out),
   .checksum_refresh_out(checksum_refresh_out),
   .tier1_summary_out(tier1_summary_out)
);

// ===== dv/host_port_model.sv
// Host model issuing register strobes
`timescale 1ns/1ps
module host_port_model (
   // Clock
   input wire logic ref_clk_in,
   // Register port
   output logic [11:0] reg_addr_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic [15:0] reg_wdata_out,
   input wire logic [15:0] reg_rdata_in,
   input wire logic reg_rvalid_in
);
   initial begin
      reg_addr_out = 12'h0000;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_wdata_out = 16'h0000;
   end
   task automatic wr(input logic [11:0] a, input logic [15:0] dv);
      @(posedge ref_clk_in) #1;
      reg_addr_out = a;
      reg_wdata_out = dv;
      reg_wr_out = 1'b1;
      @(posedge ref_clk_in) #1;
      reg_wr_out = 1'b0;
      reg_addr_out = ~a;
      reg_wdata_out = ~dv;
   endtask
   task automatic rd(input logic [11:0] a, output logic [15:0] dv, output logic vl);
      @(posedge ref_clk_in) #1;
      reg_addr_out = a;
      reg_rd_out = 1'b1;
      @(posedge ref_clk_in) #1;
      reg_rd_out = 1'b0;
      reg_addr_out = ~a;
      dv = reg_rdata_in;
      vl = reg_rvalid_in;
   endtask
endmodule

// ===== dv/metering_config_status_regs_tb.sv
// Self-checking bench for the metering register bank
`timescale 1ns/1ps
module metering_config_status_regs_tb;
   import meter_regs_pkg::*;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [11:0] addr;
   logic wr, rd, rvalid, fast, refresh, v;
   logic tvalid = 1'b0;
   logic [15:0] wdata, rdata, acc, pwr, egy, tset, gain, guard, d;
   logic [15:0] tval = 16'h0000;
   logic [2:0][15:0] ev = '0;
   logic [2:0] summ;
   int mismatches = 0;
   int samples_checked = 0;
   always #20 ref_clk_in = ~ref_clk_in;
   metering_config_status_regs u_dut (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .autocal_event_in(ev[0]), .quality_event_in(ev[1]), .fault_event_in(ev[2]),
      .thermal_value_in(tval), .thermal_valid_in(tvalid), .accum_config_out(acc),
      .power_update_interval_out(pwr), .energy_update_interval_out(egy),
      .thermal_sensor_setup_out(tset), .programmable_amplifier_gain_out(gain),
      .config_write_guard_out(guard), .uart_fast_baud_out(fast),
      .checksum_refresh_out(refresh), .tier1_summary_out(summ));
   host_port_model u_host (
      .ref_clk_in(ref_clk_in), .reg_addr_out(addr), .reg_wr_out(wr), .reg_rd_out(rd),
      .reg_wdata_out(wdata), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      samples_checked++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic give_verdict;
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [15:0] e);
      u_host.rd(a, d, v);
      chk("rvalid", {15'h0000, v}, 16'h0001);
      chk("rdata", d, e);
   endtask
   task automatic pulse(input int i, input logic [15:0] val);
      @(posedge ref_clk_in) #1;
      ev[i] = val;
      @(posedge ref_clk_in) #1;
      ev[i] = 16'h0000;
   endtask
   task automatic t_reset;
      logic [11:0] a[12] = '{12'h04b0, 12'h04b1, 12'h04b2, 12'h04b4, 12'h04b6, 12'h04b7,
         12'h04b9, 12'h04bf, 12'h04c0, 12'h04c1, 12'h04c2, 12'h04dc};
      logic [15:0] e;
      for (int i = 0; i < 12; i++) begin
         e = (i == 1 || i == 2) ? 16'h00ff : 16'h0000;
         rdchk(a[i], e);
      end
   endtask
   task automatic t_rw;
      logic [11:0] a[6] = '{12'h04b0, 12'h04b1, 12'h04b2, 12'h04b6, 12'h04b9, 12'h04bf};
      for (int i = 0; i < 6; i++) begin
         u_host.wr(a[i], 16'ha5c0 + 16'(i));
      end
      chk("acc", acc, 16'ha5c0);
      chk("pwr", pwr, 16'ha5c1);
      chk("egy", egy, 16'ha5c2);
      chk("tset", tset, 16'ha5c3);
      chk("gain", gain, 16'ha5c4);
      chk("guard", guard, 16'ha5c5);
      for (int i = 0; i < 6; i++) begin
         rdchk(a[i], 16'ha5c0 + 16'(i));
      end
      @(posedge ref_clk_in) #1;
      tval = 16'h0c35;
      tvalid = 1'b1;
      @(posedge ref_clk_in) #1;
      tvalid = 1'b0;
      tval = 16'hf3ca;
      u_host.wr(12'h04b7, 16'hffff);
      u_host.wr(12'h04c1, 16'hffff);
      rdchk(12'h04b7, 16'h0c35);
      rdchk(12'h04c1, 16'h0000);
      rdchk(12'h04b3, 16'h0000);
   endtask
   task automatic t_flags;
      for (int i = 0; i < 3; i++) begin
         pulse(i, 16'h8001);
         chk("summary", {13'h0000, summ}, 16'h0001 << i);
         fork
            rdchk(12'h04c0 + 12'(i), 16'h8001);
            pulse(i, 16'h0100);
         join
         chk("summary", {13'h0000, summ}, 16'h0001 << i);
         rdchk(12'h04c0 + 12'(i), 16'h0100);
         chk("summary", {13'h0000, summ}, 16'h0000);
         rdchk(12'h04c0 + 12'(i), 16'h0000);
      end
   endtask
   task automatic t_baud;
      logic [15:0] c[4] = '{16'h0052, 16'h0053, 16'h0052, 16'h0000};
      for (int i = 0; i < 4; i++) begin
         u_host.wr(12'h04dc, c[i]);
         chk("baud", {15'h0000, fast}, {15'h0000, c[i] == 16'h0052});
      end
      rdchk(12'h04dc, 16'h0000);
      chk("baud", {15'h0000, fast}, 16'h0000);
   endtask
   task automatic t_refresh;
      u_host.wr(12'h04b4, 16'h1234);
      chk("refresh", {15'h0000, refresh}, 16'h0001);
      @(posedge ref_clk_in) #1;
      chk("refresh", {15'h0000, refresh}, 16'h0000);
      rdchk(12'h04b4, 16'h0000);
      chk("refresh", {15'h0000, refresh}, 16'h0000);
   endtask
   task automatic t_mid_reset;
      u_host.wr(12'h04b0, 16'h5678);
      u_host.wr(12'h04b1, 16'h1234);
      u_host.wr(12'h04dc, 16'h0052);
      pulse(1, 16'h0040);
      chk("summary", {13'h0000, summ}, 16'h0002);
      @(posedge ref_clk_in) #1;
      rst_in = 1'b1;
      repeat (2) @(posedge ref_clk_in);
      #1;
      rst_in = 1'b0;
      chk("acc", acc, 16'h0000);
      chk("pwr", pwr, 16'h00ff);
      chk("egy", egy, 16'h00ff);
      chk("tset", tset, 16'h0000);
      chk("gain", gain, 16'h0000);
      chk("guard", guard, 16'h0000);
      chk("baud", {15'h0000, fast}, 16'h0000);
      chk("summary", {13'h0000, summ}, 16'h0000);
      rdchk(12'h04c1, 16'h0000);
      rdchk(12'h04b1, 16'h00ff);
   endtask
   initial begin
      repeat (20) @(posedge ref_clk_in);
      #1;
      rst_in = 1'b0;
      t_reset;
      t_rw;
      t_flags;
      t_baud;
      t_refresh;
      t_mid_reset;
      give_verdict;
   end
   initial begin
      repeat (3000) @(posedge ref_clk_in);
      mismatches++;
      give_verdict;
   end
endmodule
